// File: rtl/rms_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef RMS_REGS_SVH
`define RMS_REGS_SVH
`define RMS_OFF_CTRL       8'h00
`define RMS_OFF_STATUS     8'h04
`define RMS_OFF_CONFIG     8'h08
`define RMS_CTRL_REARM_BIT 0
`define RMS_CTRL_RESET     32'h0000_0000
`define RMS_CORE_CLK_NS    50
`define RMS_ALIGN_STEP_NS  1000
`define RMS_ALIGN_STEP_CYC \
	(((`RMS_ALIGN_STEP_NS) + (`RMS_CORE_CLK_NS) - 1) / (`RMS_CORE_CLK_NS))
`define RMS_MULT_LOW       8'h0C
`define RMS_MULT_HIGH      8'h08
`endif

// File: rtl/rms_pkg.sv
// Types shared by the reset and mode-select sampler
package rms_pkg;
	typedef enum logic [5:0] {
		ST_WAIT_RESET = 6'h01,
		ST_WAIT_LOCK  = 6'h02,
		ST_DESKEW     = 6'h04,
		ST_ALIGN      = 6'h08,
		ST_DONE       = 6'h10,
		ST_TEST_SEQ   = 6'h20
	} rms_state_t;
	typedef struct packed {
		logic [2:0] bus_cfg;
		logic       core_multiplier_select;
		logic [1:0] processor_identifier;
		logic       alignment_disable;
		logic       test_por_variant_n;
		logic       debug_por_select;
	} rms_cfg_t;
endpackage

// File: rtl/rms_sync_if.sv
// Interface carrying synchronised pin levels into the sampler
`timescale 1ns/1ns
interface rms_sync_if;
	logic              hreset_n;
	logic              pll_lock;
	rms_pkg::rms_cfg_t cfg;
	modport src (output hreset_n, output pll_lock, output cfg);
	modport dst (input hreset_n, input pll_lock, input cfg);
endinterface // rms_sync_if

// File: rtl/rms_pin_sync.sv
// Three-stage pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ns
module rms_pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         srst,
	// Pin in, filtered level out
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] level_out
);
	logic [W-1:0] s1_r, s2_r, s3_r, lvl_r;
	logic [W-1:0] lvl_nxt;

	always_comb begin
		lvl_nxt = lvl_r;
		for (int i = 0; i < W; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				lvl_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			s1_r  <= '0;
			s2_r  <= '0;
			s3_r  <= '0;
			lvl_r <= '0;
		end else begin
			s1_r  <= pin_in;
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign level_out = lvl_r;
endmodule // rms_pin_sync

// File: rtl/rms_sampler.sv
// Reset mode-select capture, power-on sequencer and AHB-Lite status port
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "rms_regs.svh"

// Operation
// R01 - Capture mode pins on primary reset rising edge
// R02 - Controller holds mode pins 20 before, 1000 after
// R03 - Controller settles PLL controls around bypass/reset
// R04 - Controller keeps PLL controls fixed during reset
// R05 - Reset exceeds bypass plus 800 us lock
// R06 - Power-on sequence waits for PLL lock
// R07 - Locked-running hard reset pulse at least 50 ns; the sync filter ignores a pulse not seen low at two clock edges
// R08 - Three-bit field selects core/bus clock ratio
// R09 - Multiplier select picks factor eight or twelve
// R10 - Low selects twelve, high selects eight
// R11 - Latch two-bit processor identifier at reset
// R12 - Alignment disable skips initial alignment procedure
// R13 - Alignment runs deskew first, then clock align
// R14 - Test variant input modifies power-on sequence
// R15 - Debug select high runs debug power-on
// R16 - Captured configuration holds until next release
module rms_sampler (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// Board pins
	input  wire logic        primary_hard_reset_n,
	input  wire logic        pll_locked,
	input  wire logic [2:0]  bus_cfg_pins,
	input  wire logic        core_multiplier_select,
	input  wire logic [1:0]  processor_identifier,
	input  wire logic        alignment_disable,
	input  wire logic        test_por_variant_n,
	input  wire logic        debug_por_select,
	// Captured configuration and sequence state
	output logic [2:0]       bus_ratio_sel,
	output logic [7:0]       core_multiplier,
	output logic [1:0]       proc_id,
	output logic             deskew_active,
	output logic             clk_align_active,
	output logic             por_done,
	output logic             por_debug_mode,
	output logic             por_test_variant,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	localparam int STEP_CYC = `RMS_ALIGN_STEP_CYC;
	localparam logic [4:0] STEP_LAST = 5'(STEP_CYC - 1);

	rms_sync_if sync_if ();
	rms_pkg::rms_cfg_t pin_cfg;
	assign pin_cfg = '{bus_cfg_pins, core_multiplier_select,
		processor_identifier, alignment_disable, test_por_variant_n,
		debug_por_select};

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	rms_pin_sync #(.W(11)) u_sync (
		.core_clk  (core_clk),
		.srst      (srst),
		.pin_in    ({primary_hard_reset_n, pll_locked, pin_cfg}),
		.level_out ({sync_if.hreset_n, sync_if.pll_lock, sync_if.cfg})
	);

	// --------------------------------------------------------------
	// Capture and power-on sequencer
	// --------------------------------------------------------------
	rms_pkg::rms_state_t state_r, state_nxt;
	rms_pkg::rms_cfg_t   cfg_r, cfg_nxt;
	logic                rst_d_r, rst_d_nxt;
	logic [4:0]          step_r, step_nxt;
	logic                rearm_r, rearm_nxt;
	logic                release_edge;

	// The synchronised level has a two-agree filter, so the controller's
	// 1000-clock hold window after release [R02] covers our added latency.
	assign release_edge = sync_if.hreset_n & ~rst_d_r;

	always_comb begin
		state_nxt = state_r;
		cfg_nxt   = cfg_r;
		rst_d_nxt = sync_if.hreset_n;
		step_nxt  = step_r;
		if (release_edge) begin
			cfg_nxt   = sync_if.cfg; // [R01] [R11] [R16]
			state_nxt = rms_pkg::ST_WAIT_LOCK;
			step_nxt  = '0;
		end else if (!sync_if.hreset_n) begin
			state_nxt = rms_pkg::ST_WAIT_RESET;
		end else begin
			case (state_r)
				rms_pkg::ST_WAIT_RESET: begin
					state_nxt = rms_pkg::ST_WAIT_RESET;
				end
				rms_pkg::ST_WAIT_LOCK: begin
					if (sync_if.pll_lock) begin // [R06]
						if (!cfg_r.test_por_variant_n) begin
							state_nxt = rms_pkg::ST_TEST_SEQ; // [R14]
						end else if (cfg_r.alignment_disable) begin
							state_nxt = rms_pkg::ST_DONE; // [R12]
						end else begin
							state_nxt = rms_pkg::ST_DESKEW; // [R13]
						end
					end
				end
				rms_pkg::ST_DESKEW: begin
					step_nxt = step_r + 5'h01;
					if (step_r == STEP_LAST) begin
						step_nxt  = '0;
						state_nxt = rms_pkg::ST_ALIGN; // [R13]
					end
				end
				rms_pkg::ST_ALIGN: begin
					step_nxt = step_r + 5'h01;
					if (step_r == STEP_LAST) begin
						step_nxt  = '0;
						state_nxt = rms_pkg::ST_DONE;
					end
				end
				rms_pkg::ST_TEST_SEQ: begin
					// Test variant skips alignment and finishes in one cycle
					state_nxt = rms_pkg::ST_DONE; // [R14]
				end
				rms_pkg::ST_DONE: begin
					if (rearm_r) begin
						state_nxt = rms_pkg::ST_WAIT_LOCK;
					end
				end
				default: begin
					state_nxt = rms_pkg::ST_WAIT_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_r <= rms_pkg::ST_WAIT_RESET;
			cfg_r   <= '0;
			rst_d_r <= 1'b0;
			step_r  <= '0;
		end else begin
			state_r <= state_nxt;
			cfg_r   <= cfg_nxt;
			rst_d_r <= rst_d_nxt;
			step_r  <= step_nxt;
		end
	end

	// --------------------------------------------------------------
	// Outputs from flops
	// --------------------------------------------------------------
	logic [7:0] mult_nxt;
	logic [7:0] mult_r;
	always_comb begin
		// Low selects twelve, high selects eight
		mult_nxt = cfg_r.core_multiplier_select ? `RMS_MULT_HIGH
			: `RMS_MULT_LOW; // [R09] [R10]
	end

	logic [5:0] flags_r, flags_nxt;
	always_comb begin
		flags_nxt = {state_r == rms_pkg::ST_DESKEW,
			state_r == rms_pkg::ST_ALIGN,
			state_r == rms_pkg::ST_DONE,
			cfg_r.debug_por_select, // [R15]
			~cfg_r.test_por_variant_n,
			1'b0};
	end

	logic [2:0] ratio_r;
	logic [1:0] pid_r;
	always_ff @(posedge core_clk) begin
		if (srst) begin
			mult_r  <= `RMS_MULT_LOW;
			flags_r <= '0;
			ratio_r <= '0;
			pid_r   <= '0;
		end else begin
			mult_r  <= mult_nxt;
			flags_r <= flags_nxt;
			ratio_r <= cfg_r.bus_cfg; // [R08]
			pid_r   <= cfg_r.processor_identifier; // [R11]
		end
	end

	assign core_multiplier  = mult_r;
	assign bus_ratio_sel    = ratio_r;
	assign proc_id          = pid_r;
	assign deskew_active    = flags_r[5];
	assign clk_align_active = flags_r[4];
	assign por_done         = flags_r[3];
	assign por_debug_mode   = flags_r[2];
	assign por_test_variant = flags_r[1];

	// --------------------------------------------------------------
	// AHB-Lite slave
	// --------------------------------------------------------------
	logic       ph_valid_r, ph_valid_nxt;
	logic       ph_write_r, ph_write_nxt;
	logic [7:0] ph_addr_r, ph_addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	always_comb begin
		ph_valid_nxt = hsel & hready & htrans[1];
		ph_write_nxt = hwrite;
		ph_addr_nxt  = haddr[7:0];
		rearm_nxt    = 1'b0;
		rdata_nxt    = '0;
		if (ph_valid_r && ph_write_r
			&& ph_addr_r == `RMS_OFF_CTRL) begin
			rearm_nxt = hwdata[`RMS_CTRL_REARM_BIT];
		end
		if (ph_valid_nxt && !hwrite) begin
			case (haddr[7:0])
				`RMS_OFF_STATUS: rdata_nxt = {26'h0, state_r};
				`RMS_OFF_CONFIG: rdata_nxt = {23'h0, cfg_r};
				default:         rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ph_valid_r <= 1'b0;
			ph_write_r <= 1'b0;
			ph_addr_r  <= '0;
			rearm_r    <= 1'b0;
			rdata_r    <= '0;
		end else begin
			ph_valid_r <= ph_valid_nxt;
			ph_write_r <= ph_write_nxt;
			ph_addr_r  <= ph_addr_nxt;
			rearm_r    <= rearm_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_r;
	// hsize is ignored: only whole words are supported
	logic unused_hsize;
	assign unused_hsize = ^hsize;
endmodule // rms_sampler

// File: test/rms_board.sv
// Board reset and mode-pin controller model
`timescale 1ns/1ns
module rms_board #(
	parameter int BYP_CYC  = 4000,
	parameter int LOCK_CYC = 16000
) (
	input  wire logic         core_clk,
	output logic              rst_n,
	output logic              lock,
	output rms_pkg::rms_cfg_t pins
);
	initial begin
		// Reset line idles high until the first boot pulls it low
		rst_n = 1'b1;
		lock = 1'b0;
		pins = '0;
	end
	// Reset is held past bypass plus lock time
	task automatic boot(input rms_pkg::rms_cfg_t p, input logic lk);
		// Old pins stay put well past the previous release
		repeat (1000) @(posedge core_clk);
		pins <= p; // PLL controls settle before reset falls
		repeat (25) @(posedge core_clk);
		rst_n <= 1'b0;
		lock <= 1'b0;
		repeat (BYP_CYC + LOCK_CYC) @(posedge core_clk);
		lock <= lk;
		repeat (25) @(posedge core_clk);
		rst_n <= 1'b1;
	endtask
	// Pin and lock changes outside a boot; callers keep the hold
	task automatic set_pins(input rms_pkg::rms_cfg_t p, input logic lk);
		pins <= p;
		lock <= lk;
	endtask
endmodule // rms_board

// File: test/rms_sampler_chk.sv
// Concurrent checks on the sampler's pins and sequencer flags
`timescale 1ns/1ns
module rms_sampler_chk (
	input wire logic       core_clk,
	input wire logic       srst,
	input wire logic       primary_hard_reset_n,
	input wire logic       pll_locked,
	input wire logic       alignment_disable,
	input wire logic       test_por_variant_n,
	input wire logic [2:0] bus_ratio_sel,
	input wire logic [7:0] core_multiplier,
	input wire logic [1:0] proc_id,
	input wire logic       deskew_active,
	input wire logic       clk_align_active,
	input wire logic       por_done
);
	logic [3:0] up_r;
	logic [3:0] up_nxt;
	// Cycles since release; capture lands well before 10
	always_comb begin
		up_nxt = (up_r == 4'hF) ? up_r : up_r + 4'h1;
		if (srst || !primary_hard_reset_n) up_nxt = 4'h0;
	end
	always_ff @(posedge core_clk) begin
		up_r <= up_nxt;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	a_cfg_hold: assert property (
		up_r >= 4'hA |-> $stable({bus_ratio_sel, core_multiplier, proc_id}))
		else $error("config moved while released");
	a_deskew_len: assert property ($rose(deskew_active) |->
		##19 deskew_active ##1 (!deskew_active && clk_align_active))
		else $error("deskew phase length wrong");
	a_align_len: assert property ($rose(clk_align_active) |->
		##19 clk_align_active ##1 (por_done && !clk_align_active))
		else $error("align phase length wrong");
	a_flags_excl: assert property (
		$onehot0({deskew_active, clk_align_active, por_done}))
		else $error("phase flags overlap");
	a_skip_align: assert property ($rose(deskew_active) |->
		alignment_disable == 1'b0 && test_por_variant_n == 1'b1)
		else $error("alignment ran when skipped");
	a_lock_first: assert property (
		$rose(deskew_active) || $rose(por_done) |-> $past(pll_locked, 3))
		else $error("sequence ran without lock");
	a_mult_code: assert property (
		core_multiplier == 8'h0C || core_multiplier == 8'h08)
		else $error("illegal multiplier");
	a_reset_clear: assert property ($fell(primary_hard_reset_n) |->
		##[1:8] !(deskew_active || clk_align_active || por_done))
		else $error("sequence kept after reset");
	cover property ($rose(clk_align_active));
	cover property ($rose(por_done) && alignment_disable);
	cover property ($rose(por_done) && !test_por_variant_n);
endmodule // rms_sampler_chk

bind rms_sampler rms_sampler_chk u_chk (
	.core_clk(core_clk), .srst(srst), .pll_locked(pll_locked),
	.primary_hard_reset_n(primary_hard_reset_n),
	.alignment_disable(alignment_disable),
	.test_por_variant_n(test_por_variant_n), .proc_id(proc_id),
	.bus_ratio_sel(bus_ratio_sel), .core_multiplier(core_multiplier),
	.deskew_active(deskew_active), .clk_align_active(clk_align_active),
	.por_done(por_done));

// File: test/tb.sv
// Self-checking bench for the reset mode-select sampler
`timescale 1ns/1ns
module tb;
	logic              core_clk, srst, hsel, hwrite, hreadyout, hresp;
	logic              rst_n, lock, dsk_seen, deskew_active, clk_align_active;
	logic              por_done, por_debug_mode, por_test_variant;
	logic [1:0]        htrans, proc_id;
	logic [2:0]        hsize, bus_ratio_sel;
	logic [7:0]        core_multiplier;
	logic [31:0]       haddr, hwdata, hrdata, rd;
	rms_pkg::rms_cfg_t pins;
	int                fail_count = 0;
	int                check_count = 0;
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	// Full bypass and lock time so each reset pulse is long enough
	rms_board brd (
		.core_clk(core_clk), .rst_n(rst_n), .lock(lock), .pins(pins));
	rms_sampler DUT (
		.core_clk(core_clk), .srst(srst), .primary_hard_reset_n(rst_n),
		.pll_locked(lock), .bus_cfg_pins(pins.bus_cfg),
		.core_multiplier_select(pins.core_multiplier_select),
		.processor_identifier(pins.processor_identifier),
		.alignment_disable(pins.alignment_disable),
		.test_por_variant_n(pins.test_por_variant_n),
		.debug_por_select(pins.debug_por_select),
		.bus_ratio_sel(bus_ratio_sel), .core_multiplier(core_multiplier),
		.proc_id(proc_id), .deskew_active(deskew_active),
		.clk_align_active(clk_align_active), .por_done(por_done),
		.por_debug_mode(por_debug_mode), .por_test_variant(por_test_variant),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	task automatic chk(input string n, input logic [31:0] got, exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a, wd);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk("response", 32'(hresp), 32'h0);
	endtask
	task automatic wait_done();
		dsk_seen = 1'b0;
		repeat (300) begin
			@(posedge core_clk);
			if (deskew_active === 1'b1) dsk_seen = 1'b1;
			if (por_done === 1'b1) break;
		end
		chk("done", 32'(por_done), 32'h1);
	endtask
	task automatic chk_cfg(input rms_pkg::rms_cfg_t p);
		chk("ratio", 32'(bus_ratio_sel), 32'(p.bus_cfg));
		chk("mult", 32'(core_multiplier),
			p.core_multiplier_select ? 32'h08 : 32'h0C);
		chk("id", 32'(proc_id), 32'(p.processor_identifier));
		chk("debug", 32'(por_debug_mode), 32'(p.debug_por_select));
		chk("test", 32'(por_test_variant), 32'(!p.test_por_variant_n));
		ahb(1'b0, 32'h08, 32'h0);
		chk("config reg", rd, 32'(p));
	endtask
	task automatic t_boot(input rms_pkg::rms_cfg_t p, input logic dsk);
		brd.boot(p, 1'b1);
		wait_done();
		chk("deskew ran", 32'(dsk_seen), 32'(dsk));
		chk_cfg(p);
		ahb(1'b0, 32'h04, 32'h0);
		chk("status", rd, 32'h10);
	endtask
	// Pin changes after capture must not leak; rerun keeps old config
	task automatic t_hold(input rms_pkg::rms_cfg_t p);
		repeat (1000) @(posedge core_clk); // Mode pins held
		brd.set_pins(p ^ 9'h1F9, 1'b1);
		repeat (30) @(posedge core_clk);
		chk_cfg(p);
		ahb(1'b0, 32'h0C, 32'h0);
		chk("unmapped", rd, 32'h0);
		ahb(1'b1, 32'h00, 32'h1);
		repeat (5) @(posedge core_clk);
		wait_done();
		chk("rerun", 32'(dsk_seen), 32'h1);
		chk_cfg(p);
	endtask
	task automatic t_lock(input rms_pkg::rms_cfg_t p);
		brd.boot(p, 1'b0);
		repeat (30) @(posedge core_clk);
		chk("early done", 32'(por_done), 32'h0);
		ahb(1'b0, 32'h04, 32'h0);
		chk("wait lock", rd, 32'h02);
		brd.set_pins(p, 1'b1);
		wait_done();
		chk_cfg(p);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (92000) @(posedge core_clk);
		fail_count++;
		finish_test();
	end
	initial begin
		srst = 1'b1;
		hsel = 1'b1;
		hsize = 3'b010;
		htrans = 2'b00;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		t_boot(9'h14B, 1'b1);
		t_hold(9'h14B);
		t_boot(9'h0AE, 1'b0);
		t_boot(9'h1D9, 1'b0);
		t_lock(9'h022);
		finish_test();
	end
endmodule // tb
